// File: design/atapc_regs.sv
/*
 Right AGC attack/decay time registers and the ADC digital path and
 control bus condition register, with the derived controls.
 Assumes a control bus engine on clk_sys gives single-cycle read and
 write strobes, and that the codec core supplies the global AGC times,
 the divider ratio code, DAC power and HPF enables on the same clock.
*/
`timescale 1ns/1ps
module atapc_regs (
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // register port from the control bus engine
   input wire logic [6:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // codec core status
   input wire logic [10:0] glb_attack_ms,
   input wire logic [15:0] glb_decay_ms,
   input wire logic [3:0] adc_rate_divider_ratio,
   input wire logic dac_left_pwr,
   input wire logic dac_right_pwr,
   input wire logic hpf_left_en,
   input wire logic hpf_right_en,
   input wire logic bus_err_event,
   // derived controls
   output logic [10:0] agc_r_attack_ms,
   output logic [15:0] agc_r_decay_ms,
   output logic hpf_left_prog,
   output logic hpf_right_prog,
   output logic dmic_left_sel,
   output logic dmic_right_sel,
   output logic pfilt_on_adc,
   output logic bus_err_det_en,
   output logic bus_err_clear
);

   ////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic [15:0] cap_ms(input logic [3:0] r);
      // codes 0..3 step the ratio by one half from 1 to 2.5; codes 4,5 give 3, codes 6,7 give 4, code 8 gives 5
      unique case (r)
         4'h0: cap_ms = atapc_pkg::CAP_MS_1;
         4'h1: cap_ms = atapc_pkg::CAP_MS_1P5;
         4'h2: cap_ms = atapc_pkg::CAP_MS_2;
         4'h3: cap_ms = atapc_pkg::CAP_MS_2P5;
         4'h4, 4'h5: cap_ms = atapc_pkg::CAP_MS_3;
         4'h6, 4'h7: cap_ms = atapc_pkg::CAP_MS_4;
         4'h8: cap_ms = atapc_pkg::CAP_MS_5;
         default: cap_ms = atapc_pkg::CAP_MS_5P5; // codes above 8 saturate
      endcase
   endfunction

   function automatic logic [10:0] atk_base(input logic [1:0] c);
      unique case (c)
         2'h0: atk_base = atapc_pkg::ATK_MS_0;
         2'h1: atk_base = atapc_pkg::ATK_MS_1;
         2'h2: atk_base = atapc_pkg::ATK_MS_2;
         2'h3: atk_base = atapc_pkg::ATK_MS_3;
      endcase
   endfunction

   function automatic logic [15:0] dec_base(input logic [1:0] c);
      unique case (c)
         2'h0: dec_base = atapc_pkg::DEC_MS_0;
         2'h1: dec_base = atapc_pkg::DEC_MS_1;
         2'h2: dec_base = atapc_pkg::DEC_MS_2;
         2'h3: dec_base = atapc_pkg::DEC_MS_3;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////
   // register storage

   logic [7:0] attack_q;
   logic [7:0] decay_q;
   logic [7:0] path_q;
   logic err_q;
   logic [7:0] rdata_q;
   logic wr_atk, wr_dec, wr_path, rd_path;

   assign wr_atk = reg_wr && (reg_addr == atapc_pkg::OFS_R_ATTACK);
   assign wr_dec = reg_wr && (reg_addr == atapc_pkg::OFS_R_DECAY);
   assign wr_path = reg_wr && (reg_addr == atapc_pkg::OFS_PATH);
   assign rd_path = reg_rd && (reg_addr == atapc_pkg::OFS_PATH);

   // attack and decay hold all eight bits; low bits reset to zero
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         attack_q <= atapc_pkg::RST_R_ATTACK;
         decay_q <= atapc_pkg::RST_R_DECAY;
      end else begin
         if (wr_atk) begin
            attack_q <= reg_wdata;
         end
         if (wr_dec) begin
            decay_q <= reg_wdata;
         end
      end
   end

   // path register: only bits 7..2 are writable, bit 1 always reads zero
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         path_q <= atapc_pkg::RST_PATH;
      end else if (wr_path) begin
         path_q <= reg_wdata & atapc_pkg::PATH_RW_MASK;
      end
   end

   // error status: a fresh error beats the read that would clear it
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         err_q <= 1'b0;
      end else if (bus_err_event && !path_q[atapc_pkg::POS_DET_OFF]) begin
         err_q <= 1'b1;
      end else if (rd_path) begin
         err_q <= 1'b0;
      end
   end

   // read data lands one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            atapc_pkg::OFS_R_ATTACK: rdata_q <= attack_q;
            atapc_pkg::OFS_R_DECAY: rdata_q <= decay_q;
            atapc_pkg::OFS_PATH: rdata_q <= {path_q[7:2], 1'b0, err_q};
            default: rdata_q <= 8'h00;
         endcase
      end
   end
   assign reg_rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////
   // effective AGC times

   logic [10:0] atk_local;
   logic [15:0] dec_local;
   logic [15:0] dec_pick;
   logic [15:0] dec_cap;
   logic [10:0] atk_ms_q;
   logic [15:0] dec_ms_q;

   // largest product is 11 ms x 128, which fits eleven bits
   assign atk_local = atk_base(attack_q[6:5]) << attack_q[4:2];
   // largest product is 350 ms x 128, which fits sixteen bits
   assign dec_local = dec_base(decay_q[6:5]) << decay_q[4:2];
   assign dec_pick = decay_q[atapc_pkg::POS_SRC] ? dec_local : glb_decay_ms;
   assign dec_cap = cap_ms(adc_rate_divider_ratio);

   // times are registered so the AGC sees one glitch-free value per cycle
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         atk_ms_q <= 11'h000;
         dec_ms_q <= 16'h0000;
      end else begin
         atk_ms_q <= attack_q[atapc_pkg::POS_SRC] ? atk_local : glb_attack_ms;
         dec_ms_q <= (dec_pick > dec_cap) ? dec_cap : dec_pick;
      end
   end
   assign agc_r_attack_ms = atk_ms_q;
   assign agc_r_decay_ms = dec_ms_q;

   ////////////////////////////////////////////////////////////////////
   // record path controls

   logic hpf_l_q, hpf_r_q, dmic_l_q, dmic_r_q, pfilt_q, det_q, clr_q;

   // filter routing follows the path register and core power state
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         hpf_l_q <= 1'b0;
         hpf_r_q <= 1'b0;
         dmic_l_q <= 1'b1;
         dmic_r_q <= 1'b1;
         pfilt_q <= 1'b0;
      end else begin
         hpf_l_q <= hpf_left_en && path_q[atapc_pkg::POS_HPF_L];
         hpf_r_q <= hpf_right_en && path_q[atapc_pkg::POS_HPF_R];
         dmic_l_q <= !path_q[atapc_pkg::POS_MIC + 1];
         dmic_r_q <= !path_q[atapc_pkg::POS_MIC];
         // a DAC still running owns the programmable filter
         pfilt_q <= path_q[atapc_pkg::POS_PFILT] && !dac_left_pwr && !dac_right_pwr;
      end
   end

   // detector enable, and a one-cycle clear back to the bus engine
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         det_q <= 1'b1;
         clr_q <= 1'b0;
      end else begin
         det_q <= !path_q[atapc_pkg::POS_DET_OFF];
         clr_q <= bus_err_event && !path_q[atapc_pkg::POS_DET_OFF];
      end
   end
   assign hpf_left_prog = hpf_l_q;
   assign hpf_right_prog = hpf_r_q;
   assign dmic_left_sel = dmic_l_q;
   assign dmic_right_sel = dmic_r_q;
   assign pfilt_on_adc = pfilt_q;
   assign bus_err_det_en = det_q;
   assign bus_err_clear = clr_q;

   ////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   property p_atk_local;
      attack_q[7] && $stable(attack_q) |=>
         agc_r_attack_ms == ($past(atk_base(attack_q[6:5])) << $past(attack_q[4:2]));
   endproperty
   a_atk_local: assert property (p_atk_local) else $error("local attack time wrong");

   property p_rsvd;
      rd_path |=> reg_rdata[1] == 1'b0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved path bit not zero");

   property p_dec_glb;
      !decay_q[7] && glb_decay_ms <= dec_cap |=> agc_r_decay_ms == $past(glb_decay_ms);
   endproperty
   a_dec_glb: assert property (p_dec_glb) else $error("global decay not used");

   property p_dec_base;
      decay_q[7] && decay_q[6:2] == 5'h18 |=> agc_r_decay_ms == atapc_pkg::DEC_MS_3;
   endproperty
   a_dec_base: assert property (p_dec_base) else $error("decay baseline wrong");

   property p_dec_fac;
      decay_q[7] && decay_q[6:2] == 5'h07 && adc_rate_divider_ratio == 4'hA
         |=> agc_r_decay_ms == 16'h1900;
   endproperty
   a_dec_fac: assert property (p_dec_fac) else $error("decay factor wrong");

   property p_cap;
      ##1 agc_r_decay_ms <= $past(dec_cap);
   endproperty
   a_cap: assert property (p_cap) else $error("decay above ceiling");

   property p_hpf;
      ##1 hpf_left_prog == $past(hpf_left_en && path_q[7])
         && hpf_right_prog == $past(hpf_right_en && path_q[6]);
   endproperty
   a_hpf: assert property (p_hpf) else $error("hpf coefficient select wrong");

   property p_mic;
      wr_path ##1 !wr_path |=> {dmic_left_sel, dmic_right_sel} == ~$past(reg_wdata[5:4], 2);
   endproperty
   a_mic: assert property (p_mic) else $error("microphone select wrong");

   property p_pfilt;
      (dac_left_pwr || dac_right_pwr) |=> !pfilt_on_adc;
   endproperty
   a_pfilt: assert property (p_pfilt) else $error("filter routed while DAC on");

   property p_det_off;
      path_q[2] |=> !bus_err_clear && !bus_err_det_en;
   endproperty
   a_det_off: assert property (p_det_off) else $error("detector active while off");

   property p_err_rd;
      rd_path && !bus_err_event ##1 !bus_err_event |=> reg_rdata[0] == 1'b0 || !$past(err_q);
   endproperty
   a_err_rd: assert property (p_err_rd) else $error("status not cleared by read");

   property p_err_set;
      bus_err_event && !path_q[2] |=> err_q;
   endproperty
   a_err_set: assert property (p_err_set) else $error("bus error lost");

   c_local_decay: cover property (decay_q[7] ##1 agc_r_decay_ms == dec_cap);
   c_err_read: cover property (err_q ##1 rd_path ##1 reg_rdata[0]);
   c_pfilt: cover property (pfilt_on_adc);
   c_err_race: cover property (bus_err_event && rd_path && err_q);

endmodule

// File: design/atapc_pkg.sv
/*
 Shared constants for the right AGC timing and ADC path register bank:
 register offsets, field positions, reset values and time tables.
 Assumes times are carried as whole milliseconds.
*/
package atapc_pkg;
   // register offsets on the control register port
   localparam logic [6:0] OFS_R_ATTACK = 7'h69;
   localparam logic [6:0] OFS_R_DECAY = 7'h6A;
   localparam logic [6:0] OFS_PATH = 7'h6B;

   // values after reset
   localparam logic [7:0] RST_R_ATTACK = 8'h00;
   localparam logic [7:0] RST_R_DECAY = 8'h00;
   localparam logic [7:0] RST_PATH = 8'h00;

   // field positions shared by attack and decay registers
   localparam int unsigned POS_SRC = 7;
   localparam int unsigned POS_BASE = 5;
   localparam int unsigned POS_FAC = 2;

   // field positions of the path and bus condition register
   localparam int unsigned POS_HPF_L = 7;
   localparam int unsigned POS_HPF_R = 6;
   localparam int unsigned POS_MIC = 4;
   localparam int unsigned POS_PFILT = 3;
   localparam int unsigned POS_DET_OFF = 2;
   localparam int unsigned POS_ERR = 0;
   // bits that software may change in the path register
   localparam logic [7:0] PATH_RW_MASK = 8'hFC;

   // baseline times in ms
   localparam logic [10:0] ATK_MS_0 = 11'h007;
   localparam logic [10:0] ATK_MS_1 = 11'h008;
   localparam logic [10:0] ATK_MS_2 = 11'h00A;
   localparam logic [10:0] ATK_MS_3 = 11'h00B;
   localparam logic [15:0] DEC_MS_0 = 16'h0032;
   localparam logic [15:0] DEC_MS_1 = 16'h0096;
   localparam logic [15:0] DEC_MS_2 = 16'h00FA;
   localparam logic [15:0] DEC_MS_3 = 16'h015E;

   // decay ceilings in ms, one per divider ratio 1,1.5,2,2.5,3,4,5,5.5
   localparam logic [15:0] CAP_MS_1 = 16'h0FA0;
   localparam logic [15:0] CAP_MS_1P5 = 16'h15E0;
   localparam logic [15:0] CAP_MS_2 = 16'h1F40;
   localparam logic [15:0] CAP_MS_2P5 = 16'h2580;
   localparam logic [15:0] CAP_MS_3 = 16'h2BC0;
   localparam logic [15:0] CAP_MS_4 = 16'h3E80;
   localparam logic [15:0] CAP_MS_5 = 16'h4B00;
   localparam logic [15:0] CAP_MS_5P5 = 16'h5780;
endpackage

// File: test/atapc_host.sv
/*
 Host model for the register port: one write or read strobe per call.
 Assumes the block samples strobes on the rising edge of clk_sys.
*/
`timescale 1ns/1ps
module atapc_host (
   // clock
   input wire logic clk_sys,
   // register port toward the block
   output logic [6:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata
);
   ////////////////////////////////////////////////////////////////////////////
   // idle port at time zero
   initial begin
      reg_addr = 7'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // write: software keeps reserved low bits at zero; data inverts when released
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= {d[7:2], 2'b00};
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_wdata <= ~{d[7:2], 2'b00};
   endtask

   // read: strobe held up to the sampling edge only
   task automatic rd(input logic [6:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask
endmodule

// File: test/tb.sv
/*
 Self-checking bench for the right AGC timing and ADC path registers.
 Assumes the host model drives the register port; the bench drives the rest.
*/
`timescale 1ns/1ps
module tb;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [6:0] reg_addr;
   logic reg_wr, reg_rd;
   logic [7:0] reg_wdata, reg_rdata;
   logic [10:0] glb_attack_ms = 11'h000;
   logic [15:0] glb_decay_ms = 16'h0000;
   logic [3:0] adc_rate_divider_ratio = 4'h0;
   logic dac_left_pwr = 1'b0, dac_right_pwr = 1'b0, hpf_left_en = 1'b0, hpf_right_en = 1'b0;
   logic bus_err_event = 1'b0;
   logic [10:0] agc_r_attack_ms;
   logic [15:0] agc_r_decay_ms;
   logic hpf_left_prog, hpf_right_prog, dmic_left_sel, dmic_right_sel;
   logic pfilt_on_adc, bus_err_det_en, bus_err_clear;
   logic [7:0] exp_q[$];
   logic rd_pend = 1'b0;
   logic [15:0] lfsr_q = 16'h641A;
   int errors = 0;
   int samples_checked = 0;
   logic [10:0] atk_base[4] = '{atapc_pkg::ATK_MS_0, atapc_pkg::ATK_MS_1,
                                atapc_pkg::ATK_MS_2, atapc_pkg::ATK_MS_3};
   logic [15:0] dec_base[4] = '{atapc_pkg::DEC_MS_0, atapc_pkg::DEC_MS_1,
                                atapc_pkg::DEC_MS_2, atapc_pkg::DEC_MS_3};

   atapc_regs u_atapc_regs (.clk_sys, .arst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .glb_attack_ms, .glb_decay_ms, .adc_rate_divider_ratio, .dac_left_pwr,
      .dac_right_pwr, .hpf_left_en, .hpf_right_en, .bus_err_event, .agc_r_attack_ms,
      .agc_r_decay_ms, .hpf_left_prog, .hpf_right_prog, .dmic_left_sel, .dmic_right_sel,
      .pfilt_on_adc, .bus_err_det_en, .bus_err_clear);
   atapc_host u_atapc_host (.clk_sys, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);

   // 40 MHz clock
   always #12.5 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////
   // pseudo-random source, fixed start so every run is the same
   function automatic logic [15:0] rnd();
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      return lfsr_q;
   endfunction

   // decay ceiling per divider ratio code; codes above 8 share the top one
   function automatic logic [15:0] cap(input logic [3:0] r);
      case (r)
         4'h0: return atapc_pkg::CAP_MS_1;
         4'h1: return atapc_pkg::CAP_MS_1P5;
         4'h2: return atapc_pkg::CAP_MS_2;
         4'h3: return atapc_pkg::CAP_MS_2P5;
         4'h4, 4'h5: return atapc_pkg::CAP_MS_3;
         4'h6, 4'h7: return atapc_pkg::CAP_MS_4;
         4'h8: return atapc_pkg::CAP_MS_5;
         default: return atapc_pkg::CAP_MS_5P5;
      endcase
   endfunction

   // derived output comparison
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // read data comparison
   task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // read data stands from the edge after the strobe; empty queue never matches
   always @(posedge clk_sys) begin
      if (rd_pend) begin
         cmp_rd(reg_rdata, exp_q.size() != 0 ? exp_q.pop_front() : 8'hXX);
      end
      rd_pend <= reg_rd;
   end

   // one bus error event; the clear pulse follows only with detection on
   task automatic err_pulse(input logic det_on);
      @(posedge clk_sys);
      bus_err_event <= 1'b1;
      @(posedge clk_sys);
      bus_err_event <= 1'b0;
      @(negedge clk_sys);
      cmp(bus_err_clear, det_on);
      @(negedge clk_sys);
      cmp(bus_err_clear, 1'b0);
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [7:0] a, d, p;
      logic [15:0] v, dexp;
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp({dmic_left_sel, dmic_right_sel, bus_err_det_en, pfilt_on_adc, bus_err_clear},
          16'h001C);
      @(posedge clk_sys);
      arst_n <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         exp_q.push_back(8'h00);
         u_atapc_host.rd(atapc_pkg::OFS_R_ATTACK + 7'(k));
      end
      // random settings; ratio, mic and factor codes walk through every value
      for (int i = 0; i < 40; i++) begin
         v = rnd();
         glb_attack_ms <= v[10:0];
         glb_decay_ms <= rnd();
         adc_rate_divider_ratio <= 4'(i);
         {dac_left_pwr, dac_right_pwr, hpf_left_en, hpf_right_en} <= v[15:12];
         a = {i[1:0] != 2'b00, v[6:5], 3'(i), 2'b00};
         d = {v[3], v[8:7], 3'(i + 3), 2'b00};
         p = {v[1:0], 2'(i), v[2], 3'b000};
         u_atapc_host.wr(atapc_pkg::OFS_R_ATTACK, a);
         u_atapc_host.wr(atapc_pkg::OFS_R_DECAY, d);
         u_atapc_host.wr(atapc_pkg::OFS_PATH, p);
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys);
         dexp = d[7] ? dec_base[d[6:5]] << d[4:2] : glb_decay_ms;
         if (dexp > cap(adc_rate_divider_ratio)) dexp = cap(adc_rate_divider_ratio);
         cmp(agc_r_attack_ms, a[7] ? 16'(atk_base[a[6:5]] << a[4:2])
             : 16'(glb_attack_ms));
         cmp(agc_r_decay_ms, dexp);
         cmp({hpf_left_prog, hpf_right_prog},
             {p[7] & hpf_left_en, p[6] & hpf_right_en});
         cmp({dmic_left_sel, dmic_right_sel}, {~p[5], ~p[4]});
         cmp(pfilt_on_adc, p[3] & ~dac_left_pwr & ~dac_right_pwr);
         exp_q.push_back(a);
         u_atapc_host.rd(atapc_pkg::OFS_R_ATTACK);
         exp_q.push_back(d);
         u_atapc_host.rd(atapc_pkg::OFS_R_DECAY);
         exp_q.push_back(p);
         u_atapc_host.rd(atapc_pkg::OFS_PATH);
         exp_q.push_back(8'h00);
         u_atapc_host.rd(i[0] ? 7'h6C : 7'h68);
      end
      // decay corners the random walk may miss: top baseline, full factor, clipped
      adc_rate_divider_ratio <= 4'hA;
      u_atapc_host.wr(atapc_pkg::OFS_R_DECAY, 8'hE0);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp(agc_r_decay_ms, atapc_pkg::DEC_MS_3);
      u_atapc_host.wr(atapc_pkg::OFS_R_DECAY, 8'h9C);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp(agc_r_decay_ms, 16'h1900);
      @(posedge clk_sys);
      adc_rate_divider_ratio <= 4'h0;
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp(agc_r_decay_ms, atapc_pkg::CAP_MS_1);
      // bus error with detection on, read-clear, then with detection off;
      // the unmapped write follows the path write so a decode slip would show in the path reads
      u_atapc_host.wr(atapc_pkg::OFS_PATH, 8'h00);
      u_atapc_host.wr(7'h6C, 8'hFF);
      err_pulse(1'b1);
      exp_q.push_back(8'h01);
      u_atapc_host.rd(atapc_pkg::OFS_PATH);
      exp_q.push_back(8'h00);
      u_atapc_host.rd(atapc_pkg::OFS_PATH);
      u_atapc_host.wr(atapc_pkg::OFS_PATH, 8'h04);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      cmp(bus_err_det_en, 1'b0);
      err_pulse(1'b0);
      exp_q.push_back(8'h04);
      u_atapc_host.rd(atapc_pkg::OFS_PATH);
      // bounded drain of outstanding reads
      for (int k = 0; k < 10 && exp_q.size() != 0; k++) @(posedge clk_sys);
      if (exp_q.size() != 0) errors++;
      end_of_test();
   end
endmodule
